// ==== common/amof_pkg.sv ====
// Purpose: Shared constants, types and mode tables for the operand fetch unit
// Assumes: 8-bit core, 16-bit address space, prefix bytes before the opcode
// Notes: Mode codes are supplied by the opcode table outside this unit
package amof_pkg;

  // ****************************************
  // Constants
  // ****************************************
  localparam logic [7:0] PFX_SWAP_INDEX = 8'h90;
  localparam logic [7:0] PFX_INDIRECT_SECOND_INDEX = 8'h91;
  localparam logic [7:0] PFX_MAKE_INDIRECT = 8'h92;
  localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
  localparam logic [7:0] NO_PREFIX = 8'h00;
  localparam logic [15:0] RESET_ADDR = 16'h0000;
  localparam logic [4:0] MODE_LAST = 5'h10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    AMOF_INHERENT = 5'h00, AMOF_IMMEDIATE = 5'h01, AMOF_DIR_SHORT = 5'h02,
    AMOF_DIR_LONG = 5'h03, AMOF_IDX_NONE = 5'h04, AMOF_IDX_SHORT = 5'h05,
    AMOF_IDX_LONG = 5'h06, AMOF_IND_SHORT = 5'h07, AMOF_IND_LONG = 5'h08,
    AMOF_INDIDX_SHORT = 5'h09, AMOF_INDIDX_LONG = 5'h0a, AMOF_REL_DIR = 5'h0b,
    AMOF_REL_IND = 5'h0c, AMOF_BIT_DIR = 5'h0d, AMOF_BIT_IND = 5'h0e,
    AMOF_BITREL_DIR = 5'h0f, AMOF_BITREL_IND = 5'h10
  } amof_mode_type;

  typedef enum logic [2:0] {
    FAM_INHERENT = 3'h0, FAM_IMMEDIATE = 3'h1, FAM_DIRECT = 3'h2, FAM_INDEXED = 3'h3,
    FAM_INDIRECT = 3'h4, FAM_RELATIVE = 3'h5, FAM_BIT = 3'h6
  } amof_family_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_OP = 6'h02, ST_CLASS = 6'h04,
    ST_EXT = 6'h08, ST_PTR = 6'h10, ST_DONE = 6'h20
  } amof_state_type;

  // ****************************************
  // Mode tables
  // ****************************************
  function automatic logic [1:0] ext_bytes(amof_mode_type m);
    case (m)
      AMOF_INHERENT, AMOF_IDX_NONE: ext_bytes = 2'd0;
      AMOF_DIR_LONG, AMOF_IDX_LONG, AMOF_BITREL_DIR, AMOF_BITREL_IND: ext_bytes = 2'd2;
      default: ext_bytes = 2'd1;
    endcase
  endfunction : ext_bytes

  function automatic logic [1:0] ptr_bytes(amof_mode_type m);
    case (m)
      AMOF_IND_LONG, AMOF_INDIDX_LONG: ptr_bytes = 2'd2;
      AMOF_IND_SHORT, AMOF_INDIDX_SHORT, AMOF_REL_IND, AMOF_BIT_IND,
      AMOF_BITREL_IND: ptr_bytes = 2'd1;
      default: ptr_bytes = 2'd0;
    endcase
  endfunction : ptr_bytes

  function automatic logic is_long(amof_mode_type m);
    is_long = (m == AMOF_DIR_LONG) || (m == AMOF_IDX_LONG) ||
              (m == AMOF_IND_LONG) || (m == AMOF_INDIDX_LONG);
  endfunction : is_long

  function automatic amof_family_type family_of(amof_mode_type m);
    case (m)
      AMOF_INHERENT: family_of = FAM_INHERENT;
      AMOF_IMMEDIATE: family_of = FAM_IMMEDIATE;
      AMOF_DIR_SHORT, AMOF_DIR_LONG: family_of = FAM_DIRECT;
      AMOF_IDX_NONE, AMOF_IDX_SHORT, AMOF_IDX_LONG: family_of = FAM_INDEXED;
      AMOF_REL_DIR, AMOF_REL_IND: family_of = FAM_RELATIVE;
      AMOF_BIT_DIR, AMOF_BIT_IND, AMOF_BITREL_DIR, AMOF_BITREL_IND: family_of = FAM_BIT;
      default: family_of = FAM_INDIRECT;
    endcase
  endfunction : family_of

  function automatic logic has_indirect(amof_mode_type m);
    case (m)
      AMOF_DIR_SHORT, AMOF_DIR_LONG, AMOF_IDX_SHORT, AMOF_IDX_LONG, AMOF_REL_DIR,
      AMOF_BIT_DIR, AMOF_BITREL_DIR: has_indirect = 1'b1;
      default: has_indirect = 1'b0;
    endcase
  endfunction : has_indirect

  function automatic amof_mode_type indirect_of(amof_mode_type m);
    case (m)
      AMOF_DIR_SHORT: indirect_of = AMOF_IND_SHORT;
      AMOF_DIR_LONG: indirect_of = AMOF_IND_LONG;
      AMOF_IDX_SHORT: indirect_of = AMOF_INDIDX_SHORT;
      AMOF_IDX_LONG: indirect_of = AMOF_INDIDX_LONG;
      AMOF_REL_DIR: indirect_of = AMOF_REL_IND;
      AMOF_BIT_DIR: indirect_of = AMOF_BIT_IND;
      AMOF_BITREL_DIR: indirect_of = AMOF_BITREL_IND;
      default: indirect_of = m;
    endcase
  endfunction : indirect_of

  // Unsigned add with no wrap into the byte: short forms reach 0x1fe
  function automatic logic [15:0] add_index(logic [15:0] base, logic [7:0] idx);
    add_index = base + {PAGE_ZERO_HI, idx};
  endfunction : add_index

endpackage : amof_pkg

// ==== hdl/amof_byte_fetch.sv ====
// Purpose: One-byte read from program/data memory
// Assumes: Memory holds the read level until it answers with one ack pulse
// Notes: Requests while a read is open are not allowed
`timescale 1ns/1ps
`default_nettype none
module amof_byte_fetch (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic [15:0] addr,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic done,
  output logic [7:0] data
);

  // ****************************************
  // Read handshake
  // ****************************************
  logic busy_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      mem_addr <= amof_pkg::RESET_ADDR;
    end else if (req) begin
      busy_reg <= 1'b1;
      mem_addr <= addr;
    end else if (mem_ack) begin
      busy_reg <= 1'b0;
    end
  end

  // Data is registered so the decoder never sees the raw bus
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
      data <= 8'h00;
    end else begin
      done <= busy_reg & mem_ack;
      if (busy_reg & mem_ack) begin
        data <= mem_rdata;
      end
    end
  end

  assign mem_rd = busy_reg;

endmodule : amof_byte_fetch
`default_nettype wire

// ==== hdl/amof_ea_calc.sv ====
// Purpose: Effective address and branch target from the gathered bytes
// Assumes: Two-byte values arrive high byte first
// Notes: Purely combinational; the caller registers the results
`timescale 1ns/1ps
`default_nettype none
module amof_ea_calc (
  input wire amof_pkg::amof_mode_type mode,
  input wire logic [7:0] index_val,
  input wire logic [15:0] ext_word,
  input wire logic [15:0] ptr_word,
  input wire logic [15:0] next_pc,
  output logic [15:0] eff_addr,
  output logic [15:0] branch_target
);

  // ****************************************
  // Address forming
  // ****************************************
  logic [7:0] disp;

  always_comb begin
    case (mode)
      amof_pkg::AMOF_DIR_SHORT, amof_pkg::AMOF_BIT_DIR:
        eff_addr = {amof_pkg::PAGE_ZERO_HI, ext_word[7:0]};
      amof_pkg::AMOF_DIR_LONG: eff_addr = ext_word;
      amof_pkg::AMOF_IDX_NONE: eff_addr = {amof_pkg::PAGE_ZERO_HI, index_val};
      amof_pkg::AMOF_IDX_SHORT:
        eff_addr = amof_pkg::add_index({amof_pkg::PAGE_ZERO_HI, ext_word[7:0]}, index_val);
      amof_pkg::AMOF_IDX_LONG: eff_addr = amof_pkg::add_index(ext_word, index_val);
      amof_pkg::AMOF_IND_SHORT, amof_pkg::AMOF_BIT_IND, amof_pkg::AMOF_BITREL_IND:
        eff_addr = {amof_pkg::PAGE_ZERO_HI, ptr_word[7:0]};
      amof_pkg::AMOF_IND_LONG: eff_addr = ptr_word;
      amof_pkg::AMOF_INDIDX_SHORT:
        eff_addr = amof_pkg::add_index({amof_pkg::PAGE_ZERO_HI, ptr_word[7:0]}, index_val);
      amof_pkg::AMOF_INDIDX_LONG: eff_addr = amof_pkg::add_index(ptr_word, index_val);
      amof_pkg::AMOF_BITREL_DIR: eff_addr = {amof_pkg::PAGE_ZERO_HI, ext_word[15:8]};
      default: eff_addr = amof_pkg::RESET_ADDR;
    endcase
  end

  // Indirect relative takes its offset from the pointed byte
  always_comb begin
    case (mode)
      amof_pkg::AMOF_REL_IND: disp = ptr_word[7:0];
      amof_pkg::AMOF_REL_DIR, amof_pkg::AMOF_BITREL_DIR, amof_pkg::AMOF_BITREL_IND:
        disp = ext_word[7:0];
      default: disp = 8'h00;
    endcase
  end

  // Pc already points past the branch
  assign branch_target = next_pc + {{8{disp[7]}}, disp};

endmodule : amof_ea_calc
`default_nettype wire

// ==== hdl/amof_operand_fetch.sv ====
// Purpose: Prefix, opcode and operand-address fetch for the 8-bit core
// Assumes: Outside opcode table answers MODE_CLASS in the cycle OPCODE_VALID is high
// Notes: Results are held from DONE until the next instruction completes
//
// Contract
// - Seventeen modes in seven families
// - Inherent: opcode only, no extra byte
// - Immediate: next byte is literal operand
// - Short direct: one address byte, page zero
// - Long direct: two-byte address, full space
// - Indexed address is unsigned index plus offset
// - No-offset indexed: index alone, no byte
// - Short indexed: byte offset, up to 0x1fe
// - Long indexed: word offset plus index
// - Short forms reach page zero, fewer bytes
// - Long forms cost extra bytes and cycles
// - Read-modify-write allows short forms only
// - Branch adds displacement to following pc
// - Indirect: page-zero pointer, byte or word
// - Indirect indexed: pointer value plus index
// - Relative: signed byte offset, direct or pointed
// - Prefixes 0x90, 0x92, 0x91 modify instruction
`timescale 1ns/1ps
`default_nettype none
module amof_operand_fetch (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic START,
  input wire logic [15:0] PC_IN,
  input wire logic [7:0] INDEX_X,
  input wire logic [7:0] INDEX_Y,
  input wire logic [4:0] MODE_CLASS,
  input wire logic MODE_RMW,
  output logic MEM_RD,
  output logic [15:0] MEM_ADDR,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic BUSY,
  output logic [7:0] OPCODE,
  output logic OPCODE_VALID,
  output logic DONE,
  output logic ILLEGAL,
  output logic [4:0] EFF_MODE,
  output logic [2:0] EFF_FAMILY,
  output logic [15:0] EFF_ADDR,
  output logic [7:0] OPERAND,
  output logic [15:0] NEXT_PC,
  output logic [15:0] BRANCH_TARGET,
  output logic [2:0] INSTR_LEN,
  output logic USE_SECOND_INDEX
);

  // ****************************************
  // Declarations
  // ****************************************
  amof_pkg::amof_state_type state_reg;
  amof_pkg::amof_state_type state_next;
  amof_pkg::amof_mode_type mode_reg;
  amof_pkg::amof_mode_type base_mode;
  amof_pkg::amof_mode_type class_mode;
  logic [15:0] pc_reg;
  logic [15:0] start_pc_reg;
  logic [15:0] fetch_addr_reg;
  logic fetch_req_reg;
  logic [7:0] prefix_reg;
  logic prefix_seen_reg;
  logic [7:0] opcode_reg;
  logic second_idx_reg;
  logic illegal_reg;
  logic [1:0] left_reg;
  logic [15:0] ext_word_reg;
  logic [15:0] ptr_word_reg;
  logic fetch_done;
  logic [7:0] fetch_data;
  logic byte_is_prefix;
  logic class_ok;
  logic prefix_ok;
  logic class_second;
  logic class_illegal;
  logic [7:0] ptr_addr;
  logic [7:0] index_sel;
  logic [15:0] ea_value;
  logic [15:0] target_value;
  logic [15:0] len_diff;

  // ****************************************
  // Memory reads
  // ****************************************
  amof_byte_fetch u_fetch (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .req(fetch_req_reg),
    .addr(fetch_addr_reg),
    .mem_rd(MEM_RD),
    .mem_addr(MEM_ADDR),
    .mem_rdata(MEM_RDATA),
    .mem_ack(MEM_ACK),
    .done(fetch_done),
    .data(fetch_data)
  );

  assign byte_is_prefix = (fetch_data == amof_pkg::PFX_SWAP_INDEX) ||
                          (fetch_data == amof_pkg::PFX_INDIRECT_SECOND_INDEX) ||
                          (fetch_data == amof_pkg::PFX_MAKE_INDIRECT);

  // ****************************************
  // Mode classification
  // ****************************************
  assign base_mode = amof_pkg::amof_mode_type'(MODE_CLASS);
  assign class_ok = (MODE_CLASS <= amof_pkg::MODE_LAST);

  always_comb begin
    class_mode = base_mode;
    class_second = 1'b0;
    prefix_ok = 1'b1;
    case (prefix_reg)
      amof_pkg::PFX_SWAP_INDEX: begin
        // Only inherent, immediate, direct and indexed forms can take the swap
        class_second = 1'b1;
        prefix_ok = (amof_pkg::family_of(base_mode) == amof_pkg::FAM_INHERENT) ||
                    (amof_pkg::family_of(base_mode) == amof_pkg::FAM_IMMEDIATE) ||
                    (amof_pkg::family_of(base_mode) == amof_pkg::FAM_DIRECT) ||
                    (amof_pkg::family_of(base_mode) == amof_pkg::FAM_INDEXED);
      end
      amof_pkg::PFX_MAKE_INDIRECT: begin
        class_mode = amof_pkg::indirect_of(base_mode);
        prefix_ok = amof_pkg::has_indirect(base_mode);
      end
      amof_pkg::PFX_INDIRECT_SECOND_INDEX: begin
        class_mode = amof_pkg::indirect_of(base_mode);
        class_second = 1'b1;
        prefix_ok = (base_mode == amof_pkg::AMOF_IDX_SHORT) ||
                    (base_mode == amof_pkg::AMOF_IDX_LONG);
      end
      default: begin
        class_mode = base_mode;
      end
    endcase
  end

  assign class_illegal = !class_ok || !prefix_ok ||
                         (MODE_RMW && amof_pkg::is_long(class_mode));

  // Pointer address is the first extension byte after the opcode
  assign ptr_addr = (amof_pkg::ext_bytes(mode_reg) == 2'd2) ? ext_word_reg[7:0] : fetch_data;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      amof_pkg::ST_IDLE: begin
        if (START) begin
          state_next = amof_pkg::ST_OP;
        end
      end
      amof_pkg::ST_OP: begin
        if (fetch_done && !(byte_is_prefix && !prefix_seen_reg)) begin
          state_next = amof_pkg::ST_CLASS;
        end
      end
      amof_pkg::ST_CLASS: begin
        if (class_illegal || amof_pkg::ext_bytes(class_mode) == 2'd0) begin
          state_next = amof_pkg::ST_DONE;
        end else begin
          state_next = amof_pkg::ST_EXT;
        end
      end
      amof_pkg::ST_EXT: begin
        if (fetch_done && left_reg == 2'd1) begin
          if (amof_pkg::ptr_bytes(mode_reg) != 2'd0) begin
            state_next = amof_pkg::ST_PTR;
          end else begin
            state_next = amof_pkg::ST_DONE;
          end
        end
      end
      amof_pkg::ST_PTR: begin
        if (fetch_done && left_reg == 2'd1) begin
          state_next = amof_pkg::ST_DONE;
        end
      end
      amof_pkg::ST_DONE: state_next = amof_pkg::ST_IDLE;
      default: state_next = amof_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= amof_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Fetch address and byte count
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pc_reg <= amof_pkg::RESET_ADDR;
      start_pc_reg <= amof_pkg::RESET_ADDR;
      fetch_addr_reg <= amof_pkg::RESET_ADDR;
      fetch_req_reg <= 1'b0;
      left_reg <= 2'd0;
    end else begin
      fetch_req_reg <= 1'b0;
      if (state_reg == amof_pkg::ST_IDLE && START) begin
        start_pc_reg <= PC_IN;
        fetch_addr_reg <= PC_IN;
        fetch_req_reg <= 1'b1;
        pc_reg <= PC_IN + 16'h0001;
      end else if (state_reg == amof_pkg::ST_OP && fetch_done && byte_is_prefix &&
                   !prefix_seen_reg) begin
        fetch_addr_reg <= pc_reg;
        fetch_req_reg <= 1'b1;
        pc_reg <= pc_reg + 16'h0001;
      end else if (state_reg == amof_pkg::ST_CLASS && state_next == amof_pkg::ST_EXT) begin
        // Long direct and long indexed forms load a count of two here (long indirect loads one), hence the extra cycles
        left_reg <= amof_pkg::ext_bytes(class_mode);
        fetch_addr_reg <= pc_reg;
        fetch_req_reg <= 1'b1;
        pc_reg <= pc_reg + 16'h0001;
      end else if (state_reg == amof_pkg::ST_EXT && fetch_done) begin
        if (left_reg != 2'd1) begin
          left_reg <= left_reg - 2'd1;
          fetch_addr_reg <= pc_reg;
          fetch_req_reg <= 1'b1;
          pc_reg <= pc_reg + 16'h0001;
        end else if (amof_pkg::ptr_bytes(mode_reg) != 2'd0) begin
          left_reg <= amof_pkg::ptr_bytes(mode_reg);
          fetch_addr_reg <= {amof_pkg::PAGE_ZERO_HI, ptr_addr};
          fetch_req_reg <= 1'b1;
        end
      end else if (state_reg == amof_pkg::ST_PTR && fetch_done && left_reg != 2'd1) begin
        // Pointer reads do not advance the program counter
        left_reg <= left_reg - 2'd1;
        fetch_addr_reg <= fetch_addr_reg + 16'h0001;
        fetch_req_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Prefix, opcode and mode
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prefix_reg <= amof_pkg::NO_PREFIX;
      prefix_seen_reg <= 1'b0;
      opcode_reg <= 8'h00;
      mode_reg <= amof_pkg::AMOF_INHERENT;
      second_idx_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      if (state_reg == amof_pkg::ST_IDLE && START) begin
        prefix_reg <= amof_pkg::NO_PREFIX;
        prefix_seen_reg <= 1'b0;
      end else if (state_reg == amof_pkg::ST_OP && fetch_done) begin
        // A second prefix byte is taken as the opcode
        if (byte_is_prefix && !prefix_seen_reg) begin
          prefix_reg <= fetch_data;
          prefix_seen_reg <= 1'b1;
        end else begin
          opcode_reg <= fetch_data;
        end
      end else if (state_reg == amof_pkg::ST_CLASS) begin
        mode_reg <= class_mode;
        second_idx_reg <= class_second;
        illegal_reg <= class_illegal;
      end
    end
  end

  // ****************************************
  // Extension and pointer bytes
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_word_reg <= 16'h0000;
      ptr_word_reg <= 16'h0000;
    end else begin
      if (state_reg == amof_pkg::ST_CLASS) begin
        ext_word_reg <= 16'h0000;
        ptr_word_reg <= 16'h0000;
      end else if (state_reg == amof_pkg::ST_EXT && fetch_done) begin
        ext_word_reg <= {ext_word_reg[7:0], fetch_data};
      end else if (state_reg == amof_pkg::ST_PTR && fetch_done) begin
        ptr_word_reg <= {ptr_word_reg[7:0], fetch_data};
      end
    end
  end

  // ****************************************
  // Address forming and results
  // ****************************************
  assign index_sel = second_idx_reg ? INDEX_Y : INDEX_X;

  amof_ea_calc u_ea (
    .mode(mode_reg),
    .index_val(index_sel),
    .ext_word(ext_word_reg),
    .ptr_word(ptr_word_reg),
    .next_pc(pc_reg),
    .eff_addr(ea_value),
    .branch_target(target_value)
  );

  assign len_diff = pc_reg - start_pc_reg;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      EFF_MODE <= 5'h00;
      EFF_FAMILY <= 3'h0;
      EFF_ADDR <= 16'h0000;
      OPERAND <= 8'h00;
      NEXT_PC <= 16'h0000;
      BRANCH_TARGET <= 16'h0000;
      INSTR_LEN <= 3'h0;
      USE_SECOND_INDEX <= 1'b0;
    end else begin
      DONE <= (state_reg == amof_pkg::ST_DONE);
      if (state_reg == amof_pkg::ST_DONE) begin
        ILLEGAL <= illegal_reg;
        EFF_MODE <= mode_reg;
        EFF_FAMILY <= amof_pkg::family_of(mode_reg);
        EFF_ADDR <= ea_value;
        OPERAND <= (mode_reg == amof_pkg::AMOF_IMMEDIATE) ? ext_word_reg[7:0] : 8'h00;
        NEXT_PC <= pc_reg;
        BRANCH_TARGET <= target_value;
        INSTR_LEN <= len_diff[2:0];
        USE_SECOND_INDEX <= second_idx_reg;
      end
    end
  end

  assign BUSY = (state_reg != amof_pkg::ST_IDLE);
  assign OPCODE_VALID = (state_reg == amof_pkg::ST_CLASS);
  assign OPCODE = opcode_reg;

endmodule : amof_operand_fetch
`default_nettype wire

// ==== tb/amof_operand_fetch_props.sv ====
// Purpose: Port checks of the operand fetch unit
// Assumes: One clock, async active-low reset
// Notes: Helpers hold start pc, last byte read, rmw class
`timescale 1ns/1ps
`default_nettype none
module amof_operand_fetch_props (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic START,
  input wire logic [15:0] PC_IN,
  input wire logic BUSY,
  input wire logic MEM_RD,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_ACK,
  input wire logic OPCODE_VALID,
  input wire logic [4:0] MODE_CLASS,
  input wire logic MODE_RMW,
  input wire logic DONE,
  input wire logic ILLEGAL,
  input wire logic [4:0] EFF_MODE,
  input wire logic [15:0] EFF_ADDR,
  input wire logic [7:0] OPERAND,
  input wire logic [15:0] NEXT_PC,
  input wire logic [15:0] BRANCH_TARGET,
  input wire logic [2:0] INSTR_LEN
);
  logic [15:0] pc_reg;
  logic [7:0] lb_reg;
  logic rmw_reg;
  wire logic [15:0] disp_w = {{8{lb_reg[7]}}, lb_reg};
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pc_reg <= 16'h0000;
      lb_reg <= 8'h00;
      rmw_reg <= 1'b0;
    end else begin
      if (START && !BUSY) pc_reg <= PC_IN;
      if (MEM_RD && MEM_ACK) lb_reg <= MEM_RDATA;
      if (OPCODE_VALID) rmw_reg <= MODE_RMW;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_ok;
    DONE && !ILLEGAL;
  endsequence
  sequence s_bad;
    DONE && ILLEGAL;
  endsequence
  done_gap_a: assert property (START && !BUSY |=> !DONE [*5])
    else $error("done too early");
  inh_noread_a: assert property (OPCODE_VALID && MODE_CLASS == 5'h00 |-> !MEM_RD [*3])
    else $error("read after inherent opcode");
  bad_mode_a: assert property (OPCODE_VALID && MODE_CLASS > 5'h10 |-> ##[1:3] s_bad)
    else $error("bad mode not refused");
  next_pc_a: assert property (s_ok |-> NEXT_PC == pc_reg + {13'h0, INSTR_LEN})
    else $error("next pc wrong");
  rel_disp_a: assert property (s_ok ##0 (EFF_MODE == 5'h0b || EFF_MODE == 5'h0c)
    |-> BRANCH_TARGET == NEXT_PC + disp_w) else $error("branch target wrong");
  imm_lit_a: assert property (s_ok ##0 EFF_MODE == 5'h01 |-> OPERAND == lb_reg)
    else $error("literal wrong");
  dir_short_a: assert property (s_ok ##0 EFF_MODE == 5'h02 |-> EFF_ADDR == {8'h00, lb_reg})
    else $error("short address wrong");
  long_lo_a: assert property (s_ok ##0 EFF_MODE == 5'h03 |-> EFF_ADDR[7:0] == lb_reg)
    else $error("byte order wrong");
  rmw_long_a: assert property (DONE && rmw_reg && EFF_MODE inside {5'h03, 5'h06, 5'h08, 5'h0a}
    |-> ILLEGAL) else $error("long rmw accepted");
endmodule : amof_operand_fetch_props
bind amof_operand_fetch amof_operand_fetch_props props_i (.*);
`default_nettype wire

// ==== tb/amof_mem_model.sv ====
// Purpose: Byte memory answering the fetch unit's reads
// Assumes: Ack stands one cycle, data valid only with ack
// Notes: Latency set by the bench per instruction
`timescale 1ns/1ps
`default_nettype none
module amof_mem_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rd,
  input wire logic [15:0] addr,
  output logic [7:0] rdata,
  output logic ack
);
  logic [7:0] mem [0:65535];
  int lat = 0;
  int cnt;
  logic [7:0] last_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      last_reg <= 8'h00;
    end else begin
      cnt <= (rd && !ack) ? cnt + 1 : 0;
      if (ack) last_reg <= rdata;
    end
  end
  assign ack = rd && (cnt >= lat);
  // Idle data inverted so a stale byte is never trusted
  assign rdata = ack ? mem[addr] : ~last_reg;
endmodule : amof_mem_model
`default_nettype wire

// ==== tb/amof_operand_fetch_tb.sv ====
// Purpose: Self-checking bench for the operand fetch unit
// Assumes: Memory model with random latency
// Notes: Expected values from the mode table
`timescale 1ns/1ps
`default_nettype none
module amof_operand_fetch_tb;
  typedef struct packed {
    logic ill; logic u2; logic [4:0] md; logic [2:0] fam; logic [2:0] len;
    logic [7:0] opd; logic [15:0] ea; logic [15:0] np; logic [15:0] bt;
  } amof_exp_type;
  logic CORE_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic START = 1'b0;
  logic [15:0] PC_IN = 16'h0000;
  logic [7:0] INDEX_X = 8'h00;
  logic [7:0] INDEX_Y = 8'h00;
  logic [4:0] MODE_CLASS = 5'h00;
  logic MODE_RMW = 1'b0;
  logic MEM_RD, MEM_ACK, BUSY, OPCODE_VALID, DONE, ILLEGAL, USE_SECOND_INDEX;
  logic [15:0] MEM_ADDR, EFF_ADDR, NEXT_PC, BRANCH_TARGET;
  logic [7:0] MEM_RDATA, OPCODE, OPERAND;
  logic [4:0] EFF_MODE;
  logic [2:0] EFF_FAMILY, INSTR_LEN;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h000128e3;
  amof_exp_type exp_q[$];
  int fam_tab[17] = '{0, 1, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5, 6, 6, 6, 6};
  int ext_tab[17] = '{0, 1, 1, 2, 0, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2};
  logic [7:0] pf_tab[4] = '{8'h00, 8'h90, 8'h92, 8'h91};
  amof_operand_fetch dut (.*);
  amof_mem_model mdl (.clk(CORE_CLK), .arst_n(ARST_N), .rd(MEM_RD), .addr(MEM_ADDR),
    .rdata(MEM_RDATA), .ack(MEM_ACK));
  initial begin
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  function automatic amof_exp_type ref_of(logic [15:0] p, logic [7:0] pf, logic [4:0] m,
    logic rmw, logic [7:0] x, logic [7:0] y);
    amof_exp_type e;
    logic [15:0] a, w, ix;
    logic [7:0] b0, b1, pb, d;
    logic [4:0] mp;
    e = '0;
    a = p + {15'h0, pf != 8'h00} + 16'h0001;
    b0 = mdl.mem[a];
    b1 = mdl.mem[a + 16'h0001];
    pb = mdl.mem[{8'h00, b0}];
    w = {pb, mdl.mem[{8'h00, b0} + 16'h0001]};
    e.u2 = (pf == 8'h90 || pf == 8'h91);
    ix = {8'h00, e.u2 ? y : x};
    mp = m;
    if (pf == 8'h92 && m inside {2, 3, 5, 6, 11, 13, 15})
      mp = m + ((m < 4) ? 5'h05 : (m < 7) ? 5'h04 : 5'h01);
    if (pf == 8'h91 && m inside {5, 6}) mp = m + 5'h04;
    e.ill = (m > 16) || (pf == 8'h90 && m > 6) || (pf != 8'h00 && pf != 8'h90 && mp == m)
      || (rmw && mp inside {3, 6, 8, 10});
    if (e.ill) return e;
    e.md = mp;
    e.fam = 3'(fam_tab[mp]);
    e.len = 3'(ext_tab[mp] + 1 + int'(pf != 8'h00));
    e.np = p + {13'h0, e.len};
    case (mp)
      2, 13, 15: e.ea = {8'h00, b0};
      3: e.ea = {b0, b1};
      4: e.ea = ix;
      5: e.ea = {8'h00, b0} + ix;
      6: e.ea = {b0, b1} + ix;
      7, 14, 16: e.ea = {8'h00, pb};
      8: e.ea = w;
      9: e.ea = {8'h00, pb} + ix;
      10: e.ea = w + ix;
      default: e.ea = 16'h0000;
    endcase
    d = (mp == 11) ? b0 : (mp == 12) ? pb : (mp > 14) ? b1 : 8'h00;
    e.bt = e.np + {{8{d[7]}}, d};
    e.opd = (mp == 1) ? b0 : 8'h00;
    return e;
  endfunction : ref_of
  task automatic run_one(input logic [4:0] m, input logic [7:0] pf);
    logic [15:0] p;
    int n;
    p = 16'(rnd());
    n = 0;
    while (BUSY !== 1'b0) begin
      @(negedge CORE_CLK);
      n++;
      if (n > 200) begin
        fail_count++;
        complete_run();
      end
    end
    mdl.mem[p] = (pf != 8'h00) ? pf : (mdl.mem[p] & 8'h7f);
    mdl.lat = (rnd() % 8 == 0) ? 9 : int'(rnd() % 3);
    MODE_CLASS = m;
    MODE_RMW = 1'(rnd());
    INDEX_X = 8'(rnd());
    INDEX_Y = 8'(rnd());
    PC_IN = p;
    START = 1'b1;
    exp_q.push_back(ref_of(p, pf, m, MODE_RMW, INDEX_X, INDEX_Y));
    @(negedge CORE_CLK);
    START = 1'b0;
    // Start while busy must be ignored
    if (rnd() % 2 == 0) begin
      repeat (2) @(negedge CORE_CLK);
      START = 1'b1;
      PC_IN = ~p;
      @(negedge CORE_CLK);
      START = 1'b0;
    end
  endtask : run_one
  always @(negedge CORE_CLK) begin
    amof_exp_type e;
    if (DONE === 1'b1 && exp_q.size() == 0) chk("DONE", 16'h1, 16'h0);
    if (DONE === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("ILLEGAL", {15'h0, ILLEGAL}, {15'h0, e.ill});
      if (!e.ill) begin
        chk("EFF_MODE", {11'h0, EFF_MODE}, {11'h0, e.md});
        chk("EFF_FAMILY", {13'h0, EFF_FAMILY}, {13'h0, e.fam});
        chk("INSTR_LEN", {13'h0, INSTR_LEN}, {13'h0, e.len});
        chk("NEXT_PC", NEXT_PC, e.np);
        chk("EFF_ADDR", EFF_ADDR, e.ea);
        chk("OPERAND", {8'h0, OPERAND}, {8'h0, e.opd});
        chk("BRANCH_TARGET", BRANCH_TARGET, e.bt);
        chk("USE_SECOND_INDEX", {15'h0, USE_SECOND_INDEX}, {15'h0, e.u2});
      end
    end
  end
  initial begin
    for (int i = 0; i < 65536; i++) mdl.mem[i] = 8'(rnd());
    repeat (6) @(negedge CORE_CLK);
    ARST_N = 1'b1;
    for (int i = 0; i < 300; i++) run_one(i < 68 ? 5'(i % 17) : 5'(rnd() % 20), pf_tab[(i / 17) % 4]);
    for (int n = 0; n < 300 && exp_q.size() > 0; n++) @(negedge CORE_CLK);
    if (exp_q.size() > 0) fail_count++;
    complete_run();
  end
endmodule : amof_operand_fetch_tb
`default_nettype wire
